// ---- src/mtr_acc.v ----
// Access decoder of the timer bank: turns a processor strobe into a
// read or write of one of the twelve words at 14H to 1FH.
// Assumes address and direction are stable in the strobe cycle.
`timescale 1ns/1ps
`include "mtr_bank_regs.vh"

module mtr_acc (
	input wire i_stb,
	input wire i_rnw,
	input wire [6:0] i_addr,
	output reg o_hit,
	output reg o_rd,
	output reg o_wr,
	output reg [3:0] o_idx
);

	reg [6:0] rel;

	// Addresses outside the window belong to other banks and are ignored.
	always @* begin
		rel = i_addr - `MTR_OFS_FIRST;
		o_hit = i_stb && (i_addr >= `MTR_OFS_FIRST)
			&& (i_addr <= `MTR_OFS_LAST);
		o_rd = o_hit && i_rnw; // R14
		o_wr = o_hit && !i_rnw; // R14
		o_idx = rel[3:0];
	end

endmodule // mtr_acc

// ---- src/mtr_bank.v ----
// Timer and priority register bank of the media access controller.
// Assumes the timer engines sit outside and present their live values
// synchronous to I_CLK, and that one processor access lasts one cycle.
`timescale 1ns/1ps
`include "mtr_bank_regs.vh"

// Operation
// R1 - Read/write 16-bit max-time register at 14H.
// R2 - Write 15H loads valid-tx setting from low byte.
// R3 - Read 15H: setting low, live counter high.
// R4 - 16H reads/loads rotation timer upper bits.
// R5 - 17H reads/loads holding timer upper bits.
// R6 - 18H reads negotiated rotation upper bits.
// R7 - 19H packs low five bits of timers.
// R8 - Bit 15 of 19H shows late count.
// R9 - 18H and 19H are read-only.
// R10 - 1AH holds requested rotation low word.
// R11 - 1BH holds high word, five valid bits.
// R12 - Three queue priority registers at 1CH-1EH.
// R13 - 1FH synchronous allocation, read and write.
// R14 - Address bus, read high, write low, data.
// R15 - Some registers writable only in init mode.
// R16 - Valid-tx write ignores upper data byte.
module mtr_bank (
	input wire I_CLK,
	input wire I_RST_N,
	input wire I_STB,
	input wire I_RNW,
	input wire [6:0] I_ADDR,
	input wire [15:0] I_DATA,
	output reg [15:0] O_DATA,
	output reg O_DATA_OE,
	output reg O_ACK,
	output reg O_REFUSED,
	input wire I_INIT_MODE,
	input wire [7:0] I_VTX_COUNT,
	input wire [20:0] I_ROT_TIMER,
	input wire [20:0] I_HOLD_TIMER,
	input wire [20:0] I_NEG_ROT,
	input wire I_LATE_CNT,
	output reg [15:0] O_MAX_TIME,
	output reg [7:0] O_VTX_SETTING,
	output reg O_ROT_LOAD,
	output reg O_HOLD_LOAD,
	output reg [15:0] O_TIMER_LOAD_VAL,
	output reg [20:0] O_REQ_ROT,
	output reg [15:0] O_ASYNC_QUEUE0_PRIORITY,
	output reg [15:0] O_ASYNC_QUEUE1_PRIORITY,
	output reg [15:0] O_ASYNC_QUEUE2_PRIORITY,
	output reg [15:0] O_SYNC_ALLOC
);

	// Word index within the window: address minus 14H.
	localparam [3:0] IX_MAX = 4'h0;
	localparam [3:0] IX_VTX = 4'h1;
	localparam [3:0] IX_ROT = 4'h2;
	localparam [3:0] IX_HOLD = 4'h3;
	localparam [3:0] IX_NEG = 4'h4;
	localparam [3:0] IX_LOW = 4'h5;
	localparam [3:0] IX_REQL = 4'h6;
	localparam [3:0] IX_REQH = 4'h7;
	localparam [3:0] IX_ASYNC_QUEUE0_PRIORITY = 4'h8;
	localparam [3:0] IX_ASYNC_QUEUE1_PRIORITY = 4'h9;
	localparam [3:0] IX_ASYNC_QUEUE2_PRIORITY = 4'ha;
	localparam [3:0] IX_SYNC = 4'hb;

	// Decoder results and the stored words of the bank.
	wire acc_hit;
	wire acc_rd;
	wire acc_wr;
	wire [3:0] acc_idx;
	wire [11:0] init_only = `MTR_INIT_ONLY_MASK;
	wire [15:0] max_time_q;
	wire [7:0] vtx_q;
	wire [15:0] req_low_q;
	wire [15:0] req_high_q;
	wire [15:0] async_queue0_priority_q;
	wire [15:0] async_queue1_priority_q;
	wire [15:0] async_queue2_priority_q;
	wire [15:0] sync_q;

	// Combinational decode results and read-path words.
	reg wr_ok;
	reg wr_refused;
	reg [11:0] load_sel;
	reg [15:0] rd_word;
	reg [15:0] low_bits;

	// Upper word of a 21-bit timer; the three upper-word reads share it
	// so the split point between the words cannot drift between them.
	function [15:0] upper_word;
		input [20:0] t;
		begin
			upper_word = t[20:5];
		end
	endfunction

	// Low five bits of a timer, as they go into the packed word.
	// The packed word and the upper word together give the full count.
	function [4:0] low_field;
		input [20:0] t;
		begin
			low_field = t[`MTR_LOW_W-1:0];
		end
	endfunction

	// Decode of the processor strobe into a word index.
	mtr_acc u_acc (
		.i_stb(I_STB),
		.i_rnw(I_RNW),
		.i_addr(I_ADDR),
		.o_hit(acc_hit),
		.o_rd(acc_rd),
		.o_wr(acc_wr),
		.o_idx(acc_idx)
	);

	// A write to an init-only word outside init mode is dropped, so a
	// running ring cannot have its timing parameters changed under it.
	always @* begin
		wr_refused = acc_wr && init_only[acc_idx] && !I_INIT_MODE; // R15
		wr_ok = acc_wr && !wr_refused;
		load_sel = 12'h000;
		if (wr_ok) begin
			load_sel[acc_idx] = 1'b1;
		end
		// The two live views have no storage behind them, so their
		// write strobes are dropped here and the access is only acked.
		load_sel[IX_NEG] = 1'b0; // R9
		load_sel[IX_LOW] = 1'b0; // R9
	end

	// Maximum-time setting, full word.
	mtr_reg #(
		.W(16),
		.RST(`MTR_RST_WORD)
	) u_max (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(load_sel[IX_MAX]), // R1
		.i_d(I_DATA),
		.o_q(max_time_q)
	);

	// Valid-transmission setting takes only the low byte; the upper byte
	// would be the live counter on reads and is never written back.
	mtr_reg #(
		.W(8),
		.RST(`MTR_RST_VTX)
	) u_vtx (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(load_sel[IX_VTX]), // R2
		.i_d(I_DATA[7:0]), // R16
		.o_q(vtx_q)
	);

	// Requested rotation time, low word.
	mtr_reg #(
		.W(16),
		.RST(`MTR_RST_WORD)
	) u_reql (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(load_sel[IX_REQL]), // R10
		.i_d(I_DATA),
		.o_q(req_low_q)
	);

	// Requested rotation time, high word; all bits read back.
	mtr_reg #(
		.W(16),
		.RST(`MTR_RST_WORD)
	) u_reqh (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(load_sel[IX_REQH]), // R11
		.i_d(I_DATA),
		.o_q(req_high_q)
	);

	// Priority of asynchronous queue 0.
	mtr_reg #(
		.W(16),
		.RST(`MTR_RST_WORD)
	) u_async_queue0_priority (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(load_sel[IX_ASYNC_QUEUE0_PRIORITY]), // R12
		.i_d(I_DATA),
		.o_q(async_queue0_priority_q)
	);

	// Priority of asynchronous queue 1.
	mtr_reg #(
		.W(16),
		.RST(`MTR_RST_WORD)
	) u_async_queue1_priority (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(load_sel[IX_ASYNC_QUEUE1_PRIORITY]), // R12
		.i_d(I_DATA),
		.o_q(async_queue1_priority_q)
	);

	// Priority of asynchronous queue 2.
	mtr_reg #(
		.W(16),
		.RST(`MTR_RST_WORD)
	) u_async_queue2_priority (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(load_sel[IX_ASYNC_QUEUE2_PRIORITY]), // R12
		.i_d(I_DATA),
		.o_q(async_queue2_priority_q)
	);

	// Synchronous bandwidth allocation.
	mtr_reg #(
		.W(16),
		.RST(`MTR_RST_WORD)
	) u_sync (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_load(load_sel[IX_SYNC]), // R13
		.i_d(I_DATA),
		.o_q(sync_q)
	);

	// Packed low bits of the three timers with the late flag on top.
	always @* begin
		low_bits = 16'h0000;
		low_bits[`MTR_LB_LATE] = I_LATE_CNT; // R8
		low_bits[`MTR_LB_NEG_LSB +: `MTR_LOW_W] =
			low_field(I_NEG_ROT); // R7
		low_bits[`MTR_LB_ROT_LSB +: `MTR_LOW_W] =
			low_field(I_ROT_TIMER); // R7
		low_bits[`MTR_LB_HOLD_LSB +: `MTR_LOW_W] =
			low_field(I_HOLD_TIMER); // R7
	end

	// Read selection; timer views are sampled live in the strobe cycle.
	always @* begin
		case (acc_idx)
		IX_MAX: begin
			rd_word = max_time_q; // R1
		end
		IX_VTX: begin
			rd_word = {I_VTX_COUNT, vtx_q}; // R3
		end
		IX_ROT: begin
			rd_word = upper_word(I_ROT_TIMER); // R4
		end
		IX_HOLD: begin
			rd_word = upper_word(I_HOLD_TIMER); // R5
		end
		IX_NEG: begin
			rd_word = upper_word(I_NEG_ROT); // R6
		end
		IX_LOW: begin
			rd_word = low_bits; // R7
		end
		IX_REQL: begin
			rd_word = req_low_q; // R10
		end
		IX_REQH: begin
			rd_word = req_high_q; // R11
		end
		IX_ASYNC_QUEUE0_PRIORITY: begin
			rd_word = async_queue0_priority_q; // R12
		end
		IX_ASYNC_QUEUE1_PRIORITY: begin
			rd_word = async_queue1_priority_q; // R12
		end
		IX_ASYNC_QUEUE2_PRIORITY: begin
			rd_word = async_queue2_priority_q; // R12
		end
		IX_SYNC: begin
			rd_word = sync_q; // R13
		end
		default: begin
			// Indices 12 to 15 never come with a hit; they read zero.
			rd_word = 16'h0000;
		end
		endcase
	end

	// Bus answer: data and its enable stand for one cycle after a read;
	// every access in the window is acknowledged, refused ones included.
	always @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_DATA <= 16'h0000;
			O_DATA_OE <= 1'b0;
			O_ACK <= 1'b0;
			O_REFUSED <= 1'b0;
		end else begin
			// Zero when not reading, so a merged bus sees no stale word.
			O_DATA <= acc_rd ? rd_word : 16'h0000; // R14
			O_DATA_OE <= acc_rd; // R14
			O_ACK <= acc_hit;
			O_REFUSED <= wr_refused; // R15
		end
	end

	// Diagnostic loads of the running timers go out as a one-cycle pulse
	// with the word, since the timer engines own those counters.
	always @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_ROT_LOAD <= 1'b0;
			O_HOLD_LOAD <= 1'b0;
			O_TIMER_LOAD_VAL <= 16'h0000;
		end else begin
			O_ROT_LOAD <= load_sel[IX_ROT]; // R4
			O_HOLD_LOAD <= load_sel[IX_HOLD]; // R5
			// The word holds after the pulse; only the pulse means load.
			if (load_sel[IX_ROT] || load_sel[IX_HOLD]) begin
				O_TIMER_LOAD_VAL <= I_DATA;
			end
		end
	end

	// Settings to the timer engines, retimed so every output is a flop;
	// they trail the stored registers by one cycle.
	always @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_MAX_TIME <= `MTR_RST_WORD;
			O_VTX_SETTING <= `MTR_RST_VTX;
			O_REQ_ROT <= {21{1'b0}};
			O_ASYNC_QUEUE0_PRIORITY <= `MTR_RST_WORD;
			O_ASYNC_QUEUE1_PRIORITY <= `MTR_RST_WORD;
			O_ASYNC_QUEUE2_PRIORITY <= `MTR_RST_WORD;
			O_SYNC_ALLOC <= `MTR_RST_WORD;
		end else begin
			O_MAX_TIME <= max_time_q;
			O_VTX_SETTING <= vtx_q;
			// Only five bits of the high word take part in the time.
			O_REQ_ROT <= {req_high_q[`MTR_REQ_HIGH_W-1:0],
				req_low_q}; // R11
			O_ASYNC_QUEUE0_PRIORITY <= async_queue0_priority_q;
			O_ASYNC_QUEUE1_PRIORITY <= async_queue1_priority_q;
			O_ASYNC_QUEUE2_PRIORITY <= async_queue2_priority_q;
			O_SYNC_ALLOC <= sync_q;
		end
	end

endmodule // mtr_bank

// ---- src/mtr_bank_regs.vh ----
// Offsets, field positions, widths and reset values of the timer bank.
// Assumes inclusion by bare name from the design files only.
`ifndef MTR_BANK_REGS_VH
`define MTR_BANK_REGS_VH

// Register addresses on the 7-bit processor address bus.
`define MTR_ADDR_W 7
`define MTR_DATA_W 16
`define MTR_OFS_MAX_TIME 7'h14
`define MTR_OFS_VALID_TX 7'h15
`define MTR_OFS_ROT_UPPER 7'h16
`define MTR_OFS_HOLD_UPPER 7'h17
`define MTR_OFS_NEG_UPPER 7'h18
`define MTR_OFS_LOW_BITS 7'h19
`define MTR_OFS_REQ_LOW 7'h1a
`define MTR_OFS_REQ_HIGH 7'h1b
`define MTR_OFS_ASYNC_QUEUE0_PRIORITY 7'h1c
`define MTR_OFS_ASYNC_QUEUE1_PRIORITY 7'h1d
`define MTR_OFS_ASYNC_QUEUE2_PRIORITY 7'h1e
`define MTR_OFS_SYNC_ALLOC 7'h1f
`define MTR_OFS_FIRST 7'h14
`define MTR_OFS_LAST 7'h1f
`define MTR_NUM_REGS 12

// Registers whose writes are taken only in initialization mode.
`define MTR_INIT_ONLY_MASK 12'h8c3

// Field layout of the packed low-bits word and the timers.
`define MTR_LOW_W 5
`define MTR_TIMER_W 21
`define MTR_LB_LATE 15
`define MTR_LB_NEG_LSB 10
`define MTR_LB_ROT_LSB 5
`define MTR_LB_HOLD_LSB 0
`define MTR_VTX_W 8
`define MTR_REQ_HIGH_W 5

// Reset values of the software-written registers.
`define MTR_RST_WORD 16'h0000
`define MTR_RST_VTX 8'h00

`endif

// ---- src/mtr_reg.v ----
// One software-loaded register of the timer bank.
// Assumes a synchronous active-low reset and a one-cycle load pulse.
`timescale 1ns/1ps

module mtr_reg #(
	parameter W = 16,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_load,
	input wire [W-1:0] i_d,
	output reg [W-1:0] o_q
);

	// Apart from reset, the load pulse alone changes the stored value.
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_q <= RST;
		end else if (i_load) begin
			o_q <= i_d;
		end
	end

endmodule // mtr_reg

// ---- verification/mtr_bank_props.sv ----
// Checker of the timer bank: bus answer timing and field packing.
// Assumes one clock domain and the bank's top-level ports only.
`timescale 1ns/1ps
module mtr_chk (
	input wire I_CLK,
	input wire I_RST_N,
	input wire I_STB,
	input wire I_RNW,
	input wire [6:0] I_ADDR,
	input wire [15:0] I_DATA,
	input wire I_INIT_MODE,
	input wire [20:0] I_ROT_TIMER,
	input wire [20:0] I_HOLD_TIMER,
	input wire [20:0] I_NEG_ROT,
	input wire I_LATE_CNT,
	input wire [15:0] O_DATA,
	input wire O_DATA_OE,
	input wire O_ACK,
	input wire O_REFUSED,
	input wire [15:0] O_MAX_TIME,
	input wire O_ROT_LOAD,
	input wire [15:0] O_TIMER_LOAD_VAL,
	input wire [15:0] O_ASYNC_QUEUE0_PRIORITY
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// Strobe decode; the packed word is kept because live inputs move.
	wire win = I_STB && I_ADDR >= 7'h14 && I_ADDR <= 7'h1f;
	wire wr = win && !I_RNW;
	reg [15:0] low_q;
	always @(posedge I_CLK)
		low_q <= {I_LATE_CNT, I_NEG_ROT[4:0], I_ROT_TIMER[4:0],
			I_HOLD_TIMER[4:0]};
	property p_ack;
		win |=> O_ACK;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_idle;
		!win |=> !O_ACK && !O_DATA_OE;
	endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	property p_oe;
		win && I_RNW |=> O_DATA_OE;
	endproperty
	a_oe: assert property (p_oe) else $error("no read data");
	property p_low;
		win && I_RNW && I_ADDR == 7'h19 |=> O_DATA == low_q;
	endproperty
	a_low: assert property (p_low) else $error("bad low bits");
	property p_async_queue0_priority;
		wr && I_ADDR == 7'h1c |=> ##1 O_ASYNC_QUEUE0_PRIORITY == $past(I_DATA, 2);
	endproperty
	a_async_queue0_priority: assert property (p_async_queue0_priority) else $error("bad async_queue0_priority");
	property p_diag;
		wr && I_ADDR == 7'h16 |=>
			O_ROT_LOAD && O_TIMER_LOAD_VAL == $past(I_DATA);
	endproperty
	a_diag: assert property (p_diag) else $error("bad load");
	property p_refuse;
		wr && I_ADDR == 7'h14 && !I_INIT_MODE |=> O_REFUSED;
	endproperty
	a_refuse: assert property (p_refuse) else $error("no refuse");
	property p_max;
		wr && I_ADDR == 7'h14 && I_INIT_MODE |=>
			##1 O_MAX_TIME == $past(I_DATA, 2);
	endproperty
	a_max: assert property (p_max) else $error("bad max");
endmodule // mtr_chk
bind mtr_bank mtr_chk mtr_chk_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
	.I_STB(I_STB), .I_RNW(I_RNW), .I_ADDR(I_ADDR), .I_DATA(I_DATA),
	.I_INIT_MODE(I_INIT_MODE), .I_ROT_TIMER(I_ROT_TIMER),
	.I_HOLD_TIMER(I_HOLD_TIMER), .I_NEG_ROT(I_NEG_ROT),
	.I_LATE_CNT(I_LATE_CNT), .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE),
	.O_ACK(O_ACK), .O_REFUSED(O_REFUSED), .O_MAX_TIME(O_MAX_TIME),
	.O_ROT_LOAD(O_ROT_LOAD), .O_TIMER_LOAD_VAL(O_TIMER_LOAD_VAL),
	.O_ASYNC_QUEUE0_PRIORITY(O_ASYNC_QUEUE0_PRIORITY));

// ---- verification/mtr_np.sv ----
// Processor model: one-cycle strobes on the register bus.
// Assumes the bank answers exactly one cycle after the strobe.
`timescale 1ns/1ps
module mtr_np (
	input wire i_clk,
	input wire i_ack,
	input wire [15:0] i_rdata,
	output reg o_stb,
	output reg o_rnw,
	output reg [6:0] o_addr,
	output reg [15:0] o_wdata
);
	// Idle bus values; stale data is inverted so nothing leans on it.
	initial begin
		o_stb = 1'b0;
		o_rnw = 1'b1;
		o_addr = 7'h00;
		o_wdata = 16'h0000;
	end
	// One access; the answer stands one cycle and is taken then.
	task xfer(input r, input [6:0] ad, input [15:0] w, output ack,
		output [15:0] rd);
	begin
		@(negedge i_clk);
		o_stb = 1'b1;
		o_rnw = r;
		o_addr = ad;
		o_wdata = w;
		@(negedge i_clk);
		o_stb = 1'b0;
		o_addr = 7'h00;
		o_wdata = ~w;
		ack = i_ack;
		rd = i_rdata;
	end
	endtask
endmodule // mtr_np

// ---- verification/tb_top.sv ----
// Bench of the timer bank with a processor model on the bus.
// Assumes the bank answers one cycle after each strobe.
`timescale 1ns/1ps
module tb_top;
	reg clk;
	reg rst_n;
	reg init;
	reg late;
	reg [7:0] vcnt;
	reg [20:0] rot, hold, neg;
	wire stb, rnw, ack, oe, refd, rld, hld;
	wire [6:0] addr;
	wire [15:0] wd, rdat, maxt, ldv, async_queue0_priority, async_queue1_priority, async_queue2_priority, sync;
	wire [7:0] vset;
	wire [20:0] req;
	integer fails, checks, i;
	reg a;
	reg [15:0] d;
	mtr_bank mtr_bank_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_STB(stb),
		.I_RNW(rnw), .I_ADDR(addr), .I_DATA(wd), .O_DATA(rdat),
		.O_DATA_OE(oe), .O_ACK(ack), .O_REFUSED(refd),
		.I_INIT_MODE(init), .I_VTX_COUNT(vcnt), .I_ROT_TIMER(rot),
		.I_HOLD_TIMER(hold), .I_NEG_ROT(neg), .I_LATE_CNT(late),
		.O_MAX_TIME(maxt), .O_VTX_SETTING(vset), .O_ROT_LOAD(rld),
		.O_HOLD_LOAD(hld), .O_TIMER_LOAD_VAL(ldv), .O_REQ_ROT(req),
		.O_ASYNC_QUEUE0_PRIORITY(async_queue0_priority), .O_ASYNC_QUEUE1_PRIORITY(async_queue1_priority), .O_ASYNC_QUEUE2_PRIORITY(async_queue2_priority),
		.O_SYNC_ALLOC(sync));
	mtr_np mtr_np_inst (.i_clk(clk), .i_ack(ack), .i_rdata(rdat),
		.o_stb(stb), .o_rnw(rnw), .o_addr(addr), .o_wdata(wd));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task chk(input string nm, input [20:0] seen, input [20:0] exp);
	begin
		checks = checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task acc(input r, input [6:0] ad, input [15:0] w);
		mtr_np_inst.xfer(r, ad, w, a, d);
	endtask
	// Stored words programmed in init mode, then read back.
	task t_store;
	begin
		init = 1'b1;
		for (i = 0; i < 6; i = i + 1)
			acc(1'b0, 7'h1a + i, 16'h3c00 + i);
		for (i = 0; i < 6; i = i + 1) begin
			acc(1'b1, 7'h1a + i, 16'h0000);
			chk("readback", d, 16'h3c00 + i);
		end
		chk("req", req, 21'h013c00);
		chk("async_queue1_priority", async_queue1_priority, 16'h3c03);
		chk("async_queue2_priority", async_queue2_priority, 16'h3c04);
		chk("sync", sync, 16'h3c05);
		acc(1'b0, 7'h14, 16'hbeef);
		acc(1'b1, 7'h14, 16'h0000);
		chk("max", d, 16'hbeef);
		$display("t_store done");
	end
	endtask
	// The upper byte of a valid-tx write must be dropped.
	task t_vtx;
	begin
		vcnt = 8'h9e;
		acc(1'b0, 7'h15, 16'ha5c3);
		acc(1'b1, 7'h15, 16'h0000);
		chk("vtx read", d, 16'h9ec3);
		chk("vtx set", vset, 8'hc3);
		$display("t_vtx done");
	end
	endtask
	// Live timer views, the packed word and a read-only write.
	task t_live;
	begin
		rot = 21'h1abcd5;
		hold = 21'h0f0f1e;
		neg = 21'h12345a;
		late = 1'b1;
		acc(1'b1, 7'h16, 16'h0000);
		chk("rot", d, rot[20:5]);
		acc(1'b1, 7'h17, 16'h0000);
		chk("hold", d, hold[20:5]);
		acc(1'b0, 7'h18, 16'hffff);
		chk("ro ack", a, 1'b1);
		acc(1'b1, 7'h18, 16'h0000);
		chk("neg", d, neg[20:5]);
		acc(1'b1, 7'h19, 16'h0000);
		chk("low", d, {late, neg[4:0], rot[4:0], hold[4:0]});
		acc(1'b0, 7'h16, 16'h1234);
		chk("ldval", ldv, 16'h1234);
		chk("rot load", rld, 1'b1);
		acc(1'b0, 7'h17, 16'h4321);
		chk("hold load", hld, 1'b1);
		chk("rot idle", rld, 1'b0);
		chk("ldval hold", ldv, 16'h4321);
		$display("t_live done");
	end
	endtask
	// Outside init mode a max-time write is refused; a queue 0 priority write goes on.
	task t_init;
	begin
		init = 1'b0;
		acc(1'b0, 7'h14, 16'h0001);
		chk("refused", refd, 1'b1);
		chk("refused ack", a, 1'b1);
		acc(1'b1, 7'h14, 16'h0000);
		chk("kept max", d, 16'hbeef);
		chk("max out", maxt, 16'hbeef);
		acc(1'b0, 7'h1c, 16'h7777);
		// The setting output trails the stored word by one cycle.
		@(negedge clk);
		chk("async_queue0_priority", async_queue0_priority, 16'h7777);
		acc(1'b1, 7'h20, 16'h0000);
		chk("unmapped", a, 1'b0);
		$display("t_init done");
	end
	endtask
	task complete_run;
	begin
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial begin
		fails = 0;
		checks = 0;
		rst_n = 1'b0;
		init = 1'b0;
		late = 1'b0;
		vcnt = 8'h00;
		rot = 21'h0;
		hold = 21'h0;
		neg = 21'h0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		t_store;
		t_vtx;
		t_live;
		t_init;
		complete_run;
	end
	// Watchdog: about 75 cycles are needed, so 400 means a hang.
	initial begin
		#(25 * 400);
		fails = fails + 1;
		complete_run;
	end
endmodule // tb_top
